// file: design/sdr_ctrl_regs.sv
// Control and status register bank of the step-down regulator
`timescale 1ns/100ps
module sdr_ctrl_regs (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic push_button_start_n_i,
	input wire logic hold_on_enable_i,
	input wire logic power_good_i,
	input wire logic die_hot_i,
	input wire logic die_cooled_i,
	output logic regulator_enable_o,
	output logic [sdr_pkg::SDR_LEVEL_W-1:0] output_level_code_o,
	output logic level_range_select_o,
	output logic forced_pwm_o,
	output logic level_code_valid_o,
	output logic [sdr_pkg::SDR_SS_W-1:0] soft_start_ramp_o,
	output logic soft_start_done_o,
	output logic thermal_shutdown_o
);
	import sdr_pkg::*;

	logic btn_meta_r;
	logic btn_sync_n_r;
	logic hold_meta_r;
	logic hold_sync_r;
	logic pg_meta_r;
	logic pg_sync_r;
	logic hot_meta_r;
	logic hot_sync_r;
	logic cool_meta_r;
	logic cool_sync_r;
	logic therm_off_r;
	logic reg_en_r;
	logic [SDR_LEVEL_W-1:0] level_r;
	logic range_r;
	logic mode_r;
	logic we0_r;
	logic we2_r;
	logic valid_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic level_ok;
	logic wr_level;
	logic wr_mode;
	logic wr_status;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			btn_meta_r <= 1'b1;
			btn_sync_n_r <= 1'b1;
			hold_meta_r <= 1'b0;
			hold_sync_r <= 1'b0;
		end else begin
			btn_meta_r <= push_button_start_n_i;
			btn_sync_n_r <= btn_meta_r;
			hold_meta_r <= hold_on_enable_i;
			hold_sync_r <= hold_meta_r;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pg_meta_r <= 1'b0;
			pg_sync_r <= 1'b0;
			hot_meta_r <= 1'b0;
			hot_sync_r <= 1'b0;
			cool_meta_r <= 1'b0;
			cool_sync_r <= 1'b0;
		end else begin
			pg_meta_r <= power_good_i;
			pg_sync_r <= pg_meta_r;
			hot_meta_r <= die_hot_i;
			hot_sync_r <= hot_meta_r;
			cool_meta_r <= die_cooled_i;
			cool_sync_r <= cool_meta_r;
		end
	end

	// ****************************************
	// Thermal latch and enable
	// ****************************************
	// Trip wins over cool-down in the same cycle
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			therm_off_r <= 1'b0;
		end else if (hot_sync_r) begin
			therm_off_r <= 1'b1;
		end else if (cool_sync_r) begin
			therm_off_r <= 1'b0;
		end
	end

	// Processor keeps the regulator on by raising hold-on
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_en_r <= 1'b0;
		end else begin
			reg_en_r <= (!btn_sync_n_r || hold_sync_r) && !therm_off_r && !hot_sync_r;
		end
	end

	// ****************************************
	// Register writes
	// ****************************************
	assign wr_level = reg_wr_i && (reg_addr_i == SDR_ADDR_LEVEL);
	assign wr_mode = reg_wr_i && (reg_addr_i == SDR_ADDR_MODE);
	assign wr_status = reg_wr_i && (reg_addr_i == SDR_ADDR_STATUS);

	// Level and range only taken while the system is on
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			level_r <= SDR_LEVEL_RST;
			range_r <= SDR_RANGE_RST;
		end else if (wr_level && reg_en_r) begin
			level_r <= reg_wdata_i[SDR_LEVEL_MSB:SDR_LEVEL_LSB];
			range_r <= reg_wdata_i[SDR_RANGE_BIT];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_r <= SDR_MODE_RST;
		end else if (wr_mode) begin
			mode_r <= reg_wdata_i[SDR_MODE_BIT];
		end
	end

	// Write-exact bits stored as given
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			we0_r <= SDR_WE0_RST;
			we2_r <= SDR_WE2_RST;
		end else if (wr_status) begin
			we0_r <= reg_wdata_i[SDR_WE0_BIT];
			we2_r <= reg_wdata_i[SDR_WE2_BIT];
		end
	end

	// ****************************************
	// Level code check
	// ****************************************
	assign level_ok = range_r || (level_r > SDR_LOW_NA_MAX);

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			valid_r <= 1'b0;
		end else begin
			valid_r <= level_ok;
		end
	end

	// ****************************************
	// Register reads
	// ****************************************
	always_comb begin
		rdata_nxt = SDR_UNMAPPED_RD;
		if (reg_addr_i == SDR_ADDR_LEVEL) begin
			rdata_nxt = {SDR_FILL_LEVEL, range_r, level_r};
		end else if (reg_addr_i == SDR_ADDR_MODE) begin
			rdata_nxt = {SDR_FILL_MODE, mode_r};
		end else if (reg_addr_i == SDR_ADDR_RSVD) begin
			rdata_nxt = SDR_FILL_RSVD;
		end else if (reg_addr_i == SDR_ADDR_STATUS) begin
			rdata_nxt = {SDR_FILL_STATUS, we2_r, pg_sync_r, we0_r};
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_r <= 8'h00;
		end else if (reg_rd_i) begin
			rdata_r <= rdata_nxt;
		end
	end

	// ****************************************
	// Soft-start
	// ****************************************
	sdr_soft_start u_soft_start (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.start_en_i(reg_en_r),
		.ramp_o(soft_start_ramp_o),
		.ramp_done_o(soft_start_done_o)
	);

	assign reg_rdata_o = rdata_r;
	assign regulator_enable_o = reg_en_r;
	assign output_level_code_o = level_r;
	assign level_range_select_o = range_r;
	assign forced_pwm_o = mode_r;
	assign level_code_valid_o = valid_r;
	assign thermal_shutdown_o = therm_off_r;

	// ****************************************
	// Checks
	// ****************************************
	a_level_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		(wr_level && reg_en_r) |=> (level_r == $past(reg_wdata_i[5:0])))
		else $error("level code not taken on write");

	a_range_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		(wr_level && reg_en_r) |=> (level_range_select_o == $past(reg_wdata_i[6])))
		else $error("range bit not taken on write");

	a_level_locked: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		(!reg_en_r) |=> ($stable(level_r) && $stable(range_r)))
		else $error("level changed while regulator off");

	a_code_valid: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		rst_b_i |=> (level_code_valid_o == ($past(range_r) || $past(level_r) > 6'h11)))
		else $error("level valid flag wrong");

	a_mode_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		wr_mode |=> (forced_pwm_o == $past(reg_wdata_i[0])))
		else $error("mode bit not taken on write");

	a_pgood_read: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		(reg_rd_i && reg_addr_i == SDR_ADDR_STATUS) |=> (reg_rdata_o[1] == $past(pg_sync_r)))
		else $error("power-good read mismatch");

	a_ro_fill: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		(reg_rd_i && reg_addr_i == SDR_ADDR_MODE) |=> (reg_rdata_o[7:1] == 7'h00))
		else $error("read-only bits of mode register not filler");

	a_ro_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		(reg_rd_i && reg_addr_i == SDR_ADDR_RSVD) |=> (reg_rdata_o == 8'h00))
		else $error("write reached read-only register");

	a_en_button: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		(!btn_sync_n_r && !therm_off_r && !hot_sync_r) |=> regulator_enable_o)
		else $error("regulator not enabled by button");

	a_en_release: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		(btn_sync_n_r && !hold_sync_r) |=> !regulator_enable_o)
		else $error("regulator on with no enable source");

	a_therm_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		(therm_off_r && !cool_sync_r) |=> (therm_off_r && !regulator_enable_o))
		else $error("thermal shutdown released early");

	a_therm_trip: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		hot_sync_r |=> (thermal_shutdown_o && !regulator_enable_o))
		else $error("thermal trip missed");

	a_level_read: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		(reg_rd_i && reg_addr_i == SDR_ADDR_LEVEL) |=> (reg_rdata_o ==
		{SDR_FILL_LEVEL, $past(level_range_select_o), $past(output_level_code_o)}))
		else $error("level register read mismatch");

	a_exact_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		wr_status |=> (we0_r == $past(reg_wdata_i[0]) && we2_r == $past(reg_wdata_i[2])))
		else $error("write-exact bits not stored");

	a_status_fill: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		(reg_rd_i && reg_addr_i == SDR_ADDR_STATUS) |=> (reg_rdata_o[7:3] == 5'h00))
		else $error("read-only bits of status register not filler");

	a_rdata_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data changed with no read");

	a_en_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		(hold_sync_r && !therm_off_r && !hot_sync_r) |=> regulator_enable_o)
		else $error("regulator not enabled by hold-on");

	a_mode_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		!wr_mode |=> $stable(forced_pwm_o))
		else $error("mode changed with no write");

	c_level_write: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		wr_level && reg_en_r);

	c_therm_cycle: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		$fell(thermal_shutdown_o));

	c_hold_takeover: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		regulator_enable_o && $rose(btn_sync_n_r) ##1 regulator_enable_o);

	c_pgood_read: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		reg_rd_i && reg_addr_i == SDR_ADDR_STATUS && pg_sync_r);

endmodule // sdr_ctrl_regs

// file: design/sdr_pkg.sv
// Constants, field layout and timing for the step-down regulator control bank
package sdr_pkg;

	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [7:0] SDR_ADDR_LEVEL = 8'h10;
	localparam logic [7:0] SDR_ADDR_MODE = 8'h11;
	localparam logic [7:0] SDR_ADDR_RSVD = 8'h12;
	localparam logic [7:0] SDR_ADDR_STATUS = 8'h13;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int SDR_LEVEL_MSB = 5;
	localparam int SDR_LEVEL_LSB = 0;
	localparam int SDR_RANGE_BIT = 6;
	localparam int SDR_MODE_BIT = 0;
	localparam int SDR_WE0_BIT = 0;
	localparam int SDR_PGOOD_BIT = 1;
	localparam int SDR_WE2_BIT = 2;
	localparam int SDR_LEVEL_W = 6;

	// ****************************************
	// Reset values and read-only filler
	// ****************************************
	localparam logic [5:0] SDR_LEVEL_RST = 6'h00;
	localparam logic SDR_RANGE_RST = 1'b1;
	localparam logic SDR_MODE_RST = 1'b0;
	localparam logic SDR_WE0_RST = 1'b0;
	localparam logic SDR_WE2_RST = 1'b0;
	localparam logic SDR_FILL_LEVEL = 1'b0;
	localparam logic [6:0] SDR_FILL_MODE = 7'h00;
	localparam logic [7:0] SDR_FILL_RSVD = 8'h00;
	localparam logic [4:0] SDR_FILL_STATUS = 5'h00;
	localparam logic [7:0] SDR_UNMAPPED_RD = 8'h00;

	// Highest low-range code that has no voltage
	localparam logic [5:0] SDR_LOW_NA_MAX = 6'h11;

	// ****************************************
	// Timing
	// ****************************************
	localparam int SDR_CLK_PERIOD_NS = 50;
	localparam int SDR_SS_TIME_US = 80;
	localparam int SDR_SS_CYCLES =
		(SDR_SS_TIME_US * 1000 + SDR_CLK_PERIOD_NS - 1) / SDR_CLK_PERIOD_NS;
	localparam int SDR_SS_W = 11;
	localparam logic [10:0] SDR_SS_LAST = 11'(SDR_SS_CYCLES);

	// ****************************************
	// Soft-start states
	// ****************************************
	typedef enum logic [1:0] {
		SDR_SS_IDLE = 2'b00,
		SDR_SS_RAMP = 2'b01,
		SDR_SS_DONE = 2'b10
	} sdr_ss_state_t;

endpackage

// file: design/sdr_soft_start.sv
// Soft-start reference ramp for the step-down regulator
`timescale 1ns/100ps
module sdr_soft_start (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic start_en_i,
	output logic [sdr_pkg::SDR_SS_W-1:0] ramp_o,
	output logic ramp_done_o
);
	import sdr_pkg::*;

	sdr_ss_state_t state_r;
	sdr_ss_state_t state_nxt;
	logic [SDR_SS_W-1:0] ramp_r;

	// ****************************************
	// Ramp sequencing
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SDR_SS_IDLE: begin
				if (start_en_i) begin
					state_nxt = SDR_SS_RAMP;
				end
			end
			SDR_SS_RAMP: begin
				if (!start_en_i) begin
					state_nxt = SDR_SS_IDLE;
				end else if (ramp_r == SDR_SS_LAST - 11'h001) begin
					state_nxt = SDR_SS_DONE;
				end
			end
			SDR_SS_DONE: begin
				if (!start_en_i) begin
					state_nxt = SDR_SS_IDLE;
				end
			end
			default: begin
				state_nxt = SDR_SS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= SDR_SS_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Reference only rises while enabled, restarts from zero
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ramp_r <= 11'h000;
		end else if (!start_en_i) begin
			ramp_r <= 11'h000;
		end else if (state_r == SDR_SS_RAMP) begin
			ramp_r <= ramp_r + 11'h001;
		end
	end

	assign ramp_o = ramp_r;
	assign ramp_done_o = (state_r == SDR_SS_DONE);

	// ****************************************
	// Checks
	// ****************************************
	a_ramp_step: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		(start_en_i && state_r == SDR_SS_RAMP) |=> (ramp_r == $past(ramp_r) + 11'h001))
		else $error("soft-start ramp did not advance by one");

	a_ramp_length: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		(start_en_i && state_r == SDR_SS_RAMP && ramp_r == SDR_SS_LAST - 11'h001)
		|=> (ramp_done_o && ramp_r == SDR_SS_LAST))
		else $error("soft-start did not finish at full count");

	a_ramp_restart: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		!start_en_i |=> (ramp_r == 11'h000 && !ramp_done_o))
		else $error("soft-start ramp not cleared when disabled");

	c_ramp_done: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		$rose(ramp_done_o));

endmodule // sdr_soft_start

// file: dv/sdr_host_model.sv
// Processor-side model driving the register port and the hold-on pin
`timescale 1ns/100ps
module sdr_host_model (
	input wire logic sys_clk_i,
	input wire logic [7:0] reg_rdata_i,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic hold_on_enable_o
);
	import sdr_pkg::*;
	initial begin
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		hold_on_enable_o = 1'b0;
	end
	// Idle bus shows inverted values, never the last one
	task automatic park();
		reg_addr_o <= ~reg_addr_o;
		reg_wdata_o <= ~reg_wdata_o;
	endtask
	// Gap gives slow or back-to-back requests
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, input int gap);
		repeat (gap) @(posedge sys_clk_i);
		@(posedge sys_clk_i);
		reg_addr_o <= addr;
		reg_wdata_o <= data;
		reg_wr_o <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_o <= 1'b0;
		park();
	endtask
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge sys_clk_i);
		reg_addr_o <= addr;
		reg_rd_o <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_o <= 1'b0;
		park();
		@(posedge sys_clk_i);
		#1;
		data = reg_rdata_i;
	endtask
	// Exact bits always carry their defaults
	task automatic write_status();
		write_reg(SDR_ADDR_STATUS, {5'h00, SDR_WE2_RST, 1'b0, SDR_WE0_RST}, 0);
	endtask
	task automatic set_hold_on(input logic v);
		@(posedge sys_clk_i);
		hold_on_enable_o <= v;
	endtask
endmodule // sdr_host_model

// file: dv/testbench.sv
// Self-checking testbench for the regulator control register bank
`timescale 1ns/100ps
module testbench;
	import sdr_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic button_n = 1'b1;
	logic pgood = 1'b1;
	logic die_hot = 1'b0;
	logic die_cooled = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
	logic reg_wr, reg_rd, hold_on;
	logic reg_en, range_sel, forced_pwm, level_valid, ss_done, thermal;
	logic [5:0] level_code;
	logic [10:0] ss_ramp;
	int n_errors = 0;
	int check_count = 0;
	always #25 sys_clk_i = ~sys_clk_i;
	sdr_host_model host_u (.sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
		.reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .hold_on_enable_o(hold_on));
	sdr_ctrl_regs dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.push_button_start_n_i(button_n), .hold_on_enable_i(hold_on), .power_good_i(pgood),
		.die_hot_i(die_hot), .die_cooled_i(die_cooled), .regulator_enable_o(reg_en),
		.output_level_code_o(level_code), .level_range_select_o(range_sel),
		.forced_pwm_o(forced_pwm), .level_code_valid_o(level_valid), .soft_start_ramp_o(ss_ramp),
		.soft_start_done_o(ss_done), .thermal_shutdown_o(thermal));
	// ****************************************
	// Compare and wait helpers
	// ****************************************
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_pin(input string name, input logic [10:0] exp, input logic [10:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		host_u.read_reg(addr, rd_val);
		chk_reg($sformatf("register %h", addr), exp, rd_val);
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic wait_en(input logic v, input int bound);
		for (int i = 0; i < bound && reg_en !== v; i++) begin
			cycles(1);
		end
		if (reg_en !== v) begin
			n_errors++;
			$display("wrong value enable wait expected %b seen %b", v, reg_en);
			tally_and_finish();
		end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic sc_reset_values();
		rd_chk(SDR_ADDR_LEVEL, {SDR_FILL_LEVEL, SDR_RANGE_RST, SDR_LEVEL_RST});
		rd_chk(SDR_ADDR_MODE, {SDR_FILL_MODE, SDR_MODE_RST});
		rd_chk(SDR_ADDR_RSVD, SDR_FILL_RSVD);
		rd_chk(SDR_ADDR_STATUS, {SDR_FILL_STATUS, SDR_WE2_RST, 1'b1, SDR_WE0_RST});
		rd_chk(8'h14, SDR_UNMAPPED_RD);
		host_u.write_reg(SDR_ADDR_LEVEL, 8'h07, 0);
		rd_chk(SDR_ADDR_LEVEL, {SDR_FILL_LEVEL, SDR_RANGE_RST, SDR_LEVEL_RST});
	endtask
	task automatic sc_button_start();
		@(posedge sys_clk_i);
		button_n <= 1'b0;
		cycles(3);
		chk_pin("enable by button", 11'h001, {10'h000, reg_en});
		host_u.set_hold_on(1'b1);
		button_n <= 1'b1;
		cycles(8);
		chk_pin("enable by hold-on", 11'h001, {10'h000, reg_en});
	endtask
	task automatic sc_soft_start();
		logic [10:0] prev;
		int n;
		prev = ss_ramp;
		n = 0;
		while (ss_done !== 1'b1 && n < 1700) begin
			cycles(1);
			n++;
			chk_pin("ramp step", 11'h001, {10'h000, ss_ramp >= prev});
			prev = ss_ramp;
		end
		if (ss_done !== 1'b1) begin
			n_errors++;
			$display("wrong value soft-start done expected 1 seen %b", ss_done);
			tally_and_finish();
		end
		chk_pin("ramp done", 11'h001, {10'h000, ss_done});
		chk_pin("ramp end", 11'(SDR_SS_CYCLES), ss_ramp);
		chk_pin("ramp length ok", 11'h001,
			{10'h000, n >= SDR_SS_CYCLES - 12 && n <= SDR_SS_CYCLES});
	endtask
	task automatic set_level(input logic [7:0] v, input logic valid);
		host_u.write_reg(SDR_ADDR_LEVEL, v, 0);
		cycles(2);
		chk_pin("level code", {5'h00, v[5:0]}, {5'h00, level_code});
		chk_pin("range", {10'h000, v[6]}, {10'h000, range_sel});
		chk_pin("code valid", {10'h000, valid}, {10'h000, level_valid});
		rd_chk(SDR_ADDR_LEVEL, {1'b0, v[6:0]});
	endtask
	task automatic sc_levels();
		set_level(8'hc5, 1'b1);
		set_level(8'h11, 1'b0);
		set_level(8'h12, 1'b1);
		set_level(8'h00, 1'b0);
		set_level(8'h7f, 1'b1);
	endtask
	task automatic sc_mode_and_ro();
		logic [7:0] vals [2] = '{8'hff, 8'hfe};
		foreach (vals[i]) begin
			host_u.write_reg(SDR_ADDR_MODE, vals[i], i);
			cycles(1);
			chk_pin("mode", {10'h000, vals[i][0]}, {10'h000, forced_pwm});
			rd_chk(SDR_ADDR_MODE, {SDR_FILL_MODE, vals[i][0]});
		end
		host_u.write_reg(SDR_ADDR_RSVD, 8'hff, 0);
		host_u.write_reg(8'h14, 8'hff, 0);
		rd_chk(SDR_ADDR_RSVD, SDR_FILL_RSVD);
		rd_chk(8'h14, SDR_UNMAPPED_RD);
		host_u.write_status();
		rd_chk(SDR_ADDR_STATUS, {SDR_FILL_STATUS, SDR_WE2_RST, 1'b1, SDR_WE0_RST});
	endtask
	task automatic sc_power_good();
		@(posedge sys_clk_i);
		pgood <= 1'b0;
		cycles(3);
		rd_chk(SDR_ADDR_STATUS, {SDR_FILL_STATUS, SDR_WE2_RST, 1'b0, SDR_WE0_RST});
		@(posedge sys_clk_i);
		pgood <= 1'b1;
		cycles(3);
		rd_chk(SDR_ADDR_STATUS, {SDR_FILL_STATUS, SDR_WE2_RST, 1'b1, SDR_WE0_RST});
	endtask
	task automatic sc_thermal();
		@(posedge sys_clk_i);
		die_hot <= 1'b1;
		die_cooled <= 1'b1;
		cycles(3);
		chk_pin("thermal trip", 11'h001, {10'h000, thermal});
		chk_pin("enable in trip", 11'h000, {10'h000, reg_en});
		@(posedge sys_clk_i);
		die_hot <= 1'b0;
		wait_en(1'b1, 12);
		chk_pin("thermal clear", 11'h000, {10'h000, thermal});
		@(posedge sys_clk_i);
		die_cooled <= 1'b0;
	endtask
	task automatic sc_shutdown();
		host_u.set_hold_on(1'b0);
		cycles(3);
		chk_pin("enable off", 11'h000, {10'h000, reg_en});
		cycles(2);
		chk_pin("ramp cleared", 11'h000, ss_ramp);
		host_u.write_reg(SDR_ADDR_LEVEL, 8'h05, 0);
		rd_chk(SDR_ADDR_LEVEL, 8'h7f);
	endtask
	initial begin
		repeat (8) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		@(posedge sys_clk_i);
		sc_reset_values();
		sc_button_start();
		sc_soft_start();
		sc_levels();
		sc_mode_and_ro();
		sc_power_good();
		sc_thermal();
		sc_shutdown();
		tally_and_finish();
	end
endmodule // testbench
